/* File: rtl/asp_pkg.sv */
// Shared constants and state types of the serial instruction port
package asp_pkg;

  // ----------------------------------------------------------------
  // Instruction byte layout
  // ----------------------------------------------------------------
  localparam int ASP_RW_BIT = 7;
  localparam int ASP_NB_HI = 6;
  localparam int ASP_NB_LO = 5;
  localparam int ASP_ADDR_HI = 3;

  // ----------------------------------------------------------------
  // Register byte map, most significant byte first
  // ----------------------------------------------------------------
  localparam logic [3:0] ASP_RES_BASE = 4'h0;
  localparam logic [3:0] ASP_OFS_BASE = 4'h3;
  localparam logic [3:0] ASP_GAIN_BASE = 4'h6;
  localparam logic [3:0] ASP_REG_BYTES = 4'h9;
  localparam int ASP_RES_BYTES = 3;
  localparam logic [23:0] ASP_OFS_RST = 24'h000000;
  localparam logic [23:0] ASP_GAIN_RST = 24'h800000;
  localparam int ASP_GAIN_FRAC = 23;

  // ----------------------------------------------------------------
  // Timing in master clock cycles (ref_clk is the master clock)
  // ----------------------------------------------------------------
  localparam logic [2:0] ASP_TURN_M = 3'h2;
  localparam logic [2:0] ASP_TURN_S = 3'h3;
  localparam logic [2:0] ASP_LEAD = 3'h2;
  localparam logic [2:0] ASP_REL_M = 3'h1;
  localparam logic [2:0] ASP_REL_S = 3'h2;
  localparam logic [2:0] ASP_RDY_M = 3'h3;
  localparam logic [2:0] ASP_RDY_S = 3'h4;
  localparam int ASP_LAST_GAP = 12;
  // Printed figures in tenths of a cycle, rounded up to whole cycles
  localparam int ASP_NEXT_GAP_T10 = 205;
  localparam int ASP_CS_LEAD_T10 = 55;
  localparam int ASP_RDY_LEAD_T10 = 55;
  localparam int ASP_SYNC_MIN_T10 = 105;
  localparam logic [4:0] ASP_NEXT_GAP = 5'((ASP_NEXT_GAP_T10 + 9) / 10);
  localparam logic [4:0] ASP_CS_LEAD = 5'((ASP_CS_LEAD_T10 + 9) / 10);
  localparam logic [4:0] ASP_RDY_LEAD = 5'((ASP_RDY_LEAD_T10 + 9) / 10);
  localparam logic [3:0] ASP_SYNC_MIN = 4'((ASP_SYNC_MIN_T10 + 9) / 10);

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ASP_IDLE = 3'h0,
    ASP_INS = 3'h1,
    ASP_TURN = 3'h2,
    ASP_LEAD_ST = 3'h3,
    ASP_DAT = 3'h4,
    ASP_TAIL = 3'h5
  } asp_dev_st_t;

  typedef enum logic [2:0] {
    ASP_H_IDLE = 3'h0,
    ASP_H_SEL = 3'h1,
    ASP_H_HI = 3'h2,
    ASP_H_LO = 3'h3,
    ASP_H_TURN = 3'h4,
    ASP_H_GAP = 3'h5
  } asp_host_st_t;

endpackage

/* File: rtl/asp_if.sv */
// Link between the converter end and the host end, with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface asp_if;
  logic sclk_dev_o;
  logic sclk_dev_oe;
  logic sclk_host_o;
  logic sclk_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sclk;
  logic sdio;
  logic result_ready_n;
  logic cs_n;
  logic conversion_sync_n;

  // Undriven lines rest low; a low SDIO decodes as a harmless write
  assign sclk = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'b0);
  assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b0);

  modport dev (
    input sclk, sdio, cs_n, conversion_sync_n,
    output sclk_dev_o, sclk_dev_oe, sdio_dev_o, sdio_dev_oe, result_ready_n
  );
  modport host (
    input sclk, sdio, result_ready_n,
    output sclk_host_o, sclk_host_oe, sdio_host_o, sdio_host_oe, cs_n, conversion_sync_n
  );
endinterface
`default_nettype wire

/* File: rtl/asp_fifo.sv */
// Command FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
    logic any;
  } asp_fifo_st_t;

  asp_fifo_st_t s;
  asp_fifo_st_t next_s;
  logic push;
  logic pop;

  // Pointers wrap naturally, so DEPTH must be a power of two
  always_comb begin
    next_s = s;
    push = in_valid && s.room;
    pop = s.any && out_ready;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.room = next_s.cnt != (AW+1)'(DEPTH);
    next_s.any = next_s.cnt != '0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.room <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.room;
  assign out_valid = s.any;
  assign out_data = s.mem[s.rp];
endmodule
`default_nettype wire

/* File: rtl/asp_host.sv */
// Host end: queues instructions and plays them onto the link as clock slave partner
`timescale 1ns/1ps
`default_nettype none
module asp_host
  import asp_pkg::*;
#(
  parameter int HALF = 4,
  parameter int CONV_CYCLES = 2000,
  parameter int TURN_WAIT = 12,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  asp_if.host lnk,
  input wire logic mode_master,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [31:0] cmd_data,
  input wire logic sync_req,
  output logic rsp_valid,
  output logic [23:0] rsp_data
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int FRAME_MAX = 40 + 64 * HALF + TURN_WAIT + int'(ASP_NEXT_GAP);
  localparam logic [CW-1:0] LATE_LIMIT = CW'(CONV_CYCLES - ASP_LAST_GAP - FRAME_MAX);

  typedef struct packed {
    asp_host_st_t st;
    logic [1:0][2:0] sh;
    logic [1:0] stb;
    logic [4:0] ph;
    logic [4:0] bit_i;
    logic [31:0] cmd;
    logic [23:0] rx;
    logic [CW-1:0] cnt;
    logic had;
    logic [3:0] sync_cnt;
    logic sclk_o;
    logic sclk_oe;
    logic sdio_o;
    logic sdio_oe;
    logic cs_n;
    logic sync_n;
    logic rsp_v;
  } asp_host_state_t;

  asp_host_state_t s;
  asp_host_state_t next_s;
  logic [1:0] pin;
  logic q_valid;
  logic q_pop;
  logic [31:0] q_data;
  logic start_ok;
  logic rd;
  logic [4:0] last_bit;

  assign pin = {lnk.sdio, lnk.result_ready_n};

  asp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_data)
  );

  always_comb begin
    next_s = s;
    next_s.rsp_v = 1'b0;
    next_s.sclk_oe = !mode_master;
    rd = s.cmd[24 + ASP_RW_BIT];
    last_bit = {s.cmd[24 + ASP_NB_HI:24 + ASP_NB_LO], 3'h7} + 5'h8;
    for (int i = 0; i < 2; i++) begin
      next_s.sh[i] = {s.sh[i][1:0], pin[i]};
      if (s.sh[i][2] == s.sh[i][1]) begin
        next_s.stb[i] = s.sh[i][2];
      end
    end
    // Ready strobe is used only after it has settled through the synchroniser
    if (s.stb[0] && !s.sh[0][2] && !s.sh[0][1]) begin
      next_s.cnt = '0;
      next_s.had = 1'b0;
    end else if (s.cnt != '1) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    start_ok = !mode_master && s.cnt <= LATE_LIMIT
      && ((!s.stb[0] && !s.had && s.cnt >= CW'(ASP_RDY_LEAD)) || s.had);
    q_pop = (s.st == ASP_H_IDLE) && start_ok;
    case (s.st)
      ASP_H_IDLE: begin
        next_s.ph = '0;
        next_s.bit_i = '0;
        // Select held low in master operation so the converter may run its frame
        next_s.cs_n = !mode_master;
        if (q_valid && start_ok) begin
          next_s.cmd = q_data;
          next_s.rx = '0;
          next_s.cs_n = 1'b0;
          next_s.sdio_oe = 1'b1;
          next_s.sdio_o = q_data[31];
          next_s.st = ASP_H_SEL;
        end
      end
      ASP_H_SEL: begin
        next_s.ph = s.ph + 1'b1;
        if (s.ph == ASP_CS_LEAD - 5'h1) begin
          next_s.ph = '0;
          next_s.sclk_o = 1'b1;
          next_s.st = ASP_H_HI;
        end
      end
      ASP_H_HI: begin
        next_s.ph = s.ph + 1'b1;
        if (s.ph == 5'(HALF - 1)) begin
          next_s.ph = '0;
          next_s.sclk_o = 1'b0;
          // Command stays whole so read flag and byte count hold all frame
          next_s.sdio_o = s.cmd[5'h1e - s.bit_i];
          if (rd && s.bit_i >= 5'h7) begin
            next_s.sdio_oe = 1'b0;
          end
          next_s.st = ASP_H_LO;
        end
      end
      ASP_H_LO: begin
        next_s.ph = s.ph + 1'b1;
        if (s.ph == 5'(HALF - 1)) begin
          next_s.ph = '0;
          next_s.bit_i = s.bit_i + 1'b1;
          if (rd && s.bit_i >= 5'h8) begin
            next_s.rx = {s.rx[22:0], s.stb[1]};
          end
          if (s.bit_i == last_bit) begin
            next_s.st = ASP_H_GAP;
          end else if (rd && s.bit_i == 5'h7) begin
            next_s.st = ASP_H_TURN;
          end else begin
            next_s.sclk_o = 1'b1;
            next_s.st = ASP_H_HI;
          end
        end
      end
      ASP_H_TURN: begin
        next_s.ph = s.ph + 1'b1;
        if (s.ph == 5'(TURN_WAIT - 1)) begin
          next_s.ph = '0;
          next_s.sclk_o = 1'b1;
          next_s.st = ASP_H_HI;
        end
      end
      ASP_H_GAP: begin
        next_s.sdio_oe = 1'b0;
        next_s.ph = s.ph + 1'b1;
        if (s.ph == ASP_NEXT_GAP - 5'h1) begin
          next_s.cs_n = 1'b1;
          next_s.had = 1'b1;
          next_s.rsp_v = rd;
          next_s.st = ASP_H_IDLE;
        end
      end
      default: begin
        next_s.st = ASP_H_IDLE;
      end
    endcase
    // Sync pulse is stretched to the least low time
    if (!s.sync_n) begin
      next_s.sync_cnt = s.sync_cnt + 1'b1;
      if (s.sync_cnt == ASP_SYNC_MIN - 4'h1) begin
        next_s.sync_n = 1'b1;
      end
    end else if (sync_req) begin
      next_s.sync_n = 1'b0;
      next_s.sync_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.sh <= '1;
      s.stb <= 2'h3;
      s.cs_n <= 1'b1;
      s.sync_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.sclk_host_o = s.sclk_o;
  assign lnk.sclk_host_oe = s.sclk_oe;
  assign lnk.sdio_host_o = s.sdio_o;
  assign lnk.sdio_host_oe = s.sdio_oe;
  assign lnk.cs_n = s.cs_n;
  assign lnk.conversion_sync_n = s.sync_n;
  assign rsp_valid = s.rsp_v;
  assign rsp_data = s.rx;
endmodule
`default_nettype wire

/* File: rtl/asp_dev.sv */
// Converter end: serial instruction port, register bytes and conversion timing
`timescale 1ns/1ps
`default_nettype none
module asp_dev
  import asp_pkg::*;
#(
  parameter int CONV_CYCLES = 2000
) (
  input wire logic ref_clk,
  input wire logic rst,
  asp_if.dev lnk,
  input wire logic mode_master,
  input wire logic [23:0] sample_in,
  output logic [23:0] result_out,
  output logic busy
);
  localparam int CW = $clog2(CONV_CYCLES);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
  // Restart skips the fall slot so the next fall always follows a CONV_LAST refresh slot
  localparam logic [CW-1:0] CONV_RESTART = CW'(1);

  typedef struct packed {
    asp_dev_st_t st;
    logic [3:0][2:0] sh;
    logic [3:0] stb;
    logic [7:0] ins;
    logic [7:0] shr;
    logic [2:0] bit_i;
    logic [1:0] byte_i;
    logic [2:0] wt;
    logic [CW-1:0] conv;
    logic [3:0] slow;
    logic [15:0][7:0] regs;
    logic ready_n;
    logic served;
    logic sclk_o;
    logic sclk_oe;
    logic sdio_o;
    logic sdio_oe;
    logic busy;
  } asp_dev_state_t;

  asp_dev_state_t s;
  asp_dev_state_t next_s;
  logic [3:0] pin;
  logic rd;
  logic last_byte;
  logic m_run;
  logic rise;
  logic fall;
  logic din;
  logic blocked;
  logic [3:0] addr;
  logic [7:0] rb_cur;
  logic [7:0] rb_nxt;
  logic [23:0] diff;
  logic [47:0] prod;
  logic [2:0] turn_c;
  logic [2:0] rel_c;
  logic [2:0] rdy_c;

  // ----------------------------------------------------------------
  // Pin order for the synchronisers: sclk, sdio, cs_n, sync_n
  // ----------------------------------------------------------------
  assign pin = {lnk.conversion_sync_n, lnk.cs_n, lnk.sdio, lnk.sclk};

  always_comb begin
    next_s = s;
    for (int i = 0; i < 4; i++) begin
      next_s.sh[i] = {s.sh[i][1:0], pin[i]};
      if (s.sh[i][2] == s.sh[i][1]) begin
        next_s.stb[i] = s.sh[i][2];
      end
    end
    rd = s.ins[ASP_RW_BIT];
    last_byte = s.byte_i == s.ins[ASP_NB_HI:ASP_NB_LO];
    addr = s.ins[ASP_ADDR_HI:0] + {2'h0, s.byte_i};
    rb_cur = (addr < ASP_REG_BYTES) ? s.regs[addr] : 8'h00;
    rb_nxt = (addr + 4'h1 < ASP_REG_BYTES) ? s.regs[addr + 4'h1] : 8'h00;
    turn_c = mode_master ? ASP_TURN_M : ASP_TURN_S;
    rel_c = mode_master ? ASP_REL_M : ASP_REL_S;
    rdy_c = mode_master ? ASP_RDY_M : ASP_RDY_S;
    // ----------------------------------------------------------------
    // Serial clock: made here at half rate, or found on the pin
    // ----------------------------------------------------------------
    m_run = mode_master && (s.st == ASP_INS || s.st == ASP_DAT);
    next_s.sclk_oe = mode_master;
    next_s.sclk_o = m_run ? !s.sclk_o : 1'b0;
    if (mode_master) begin
      rise = m_run && !s.sclk_o;
      fall = m_run && s.sclk_o;
    end else begin
      rise = !s.stb[0] && s.sh[0][2] && s.sh[0][1];
      fall = s.stb[0] && !s.sh[0][2] && !s.sh[0][1];
    end
    // Master reads lag the pin by the synchroniser; host must hold data two cycles
    din = s.stb[1];
    case (s.st)
      ASP_IDLE: begin
        next_s.bit_i = '0;
        next_s.byte_i = '0;
        next_s.wt = '0;
        if (mode_master) begin
          if (!s.stb[2] && !s.ready_n && !s.served) begin
            next_s.served = 1'b1;
            next_s.st = ASP_INS;
          end
        end else if (!s.stb[2] && rise) begin
          next_s.ins = {s.ins[6:0], din};
          next_s.st = ASP_INS;
        end
      end
      ASP_INS: begin
        if (rise) begin
          next_s.ins = {s.ins[6:0], din};
        end
        if (fall) begin
          next_s.bit_i = s.bit_i + 1'b1;
          if (s.bit_i == 3'h7) begin
            next_s.st = rd ? ASP_TURN : ASP_DAT;
          end
        end
      end
      ASP_TURN: begin
        next_s.wt = s.wt + 1'b1;
        if (s.wt == turn_c - 3'h1) begin
          next_s.wt = '0;
          next_s.sdio_oe = 1'b1;
          next_s.shr = rb_cur;
          next_s.sdio_o = rb_cur[7];
          next_s.st = ASP_LEAD_ST;
        end
      end
      ASP_LEAD_ST: begin
        next_s.wt = s.wt + 1'b1;
        if (s.wt == ASP_LEAD - 3'h1) begin
          next_s.wt = '0;
          next_s.st = ASP_DAT;
        end
      end
      ASP_DAT: begin
        if (rise && !rd) begin
          next_s.shr = {s.shr[6:0], din};
        end
        if (fall) begin
          next_s.bit_i = s.bit_i + 1'b1;
          if (rd) begin
            next_s.shr = {s.shr[6:0], 1'b0};
            next_s.sdio_o = s.shr[6];
          end
          if (s.bit_i == 3'h7) begin
            next_s.byte_i = s.byte_i + 1'b1;
            // Result bytes are read-only; writes there do nothing
            if (!rd && addr >= ASP_OFS_BASE && addr < ASP_REG_BYTES) begin
              next_s.regs[addr] = s.shr;
            end
            if (rd) begin
              next_s.shr = rb_nxt;
              next_s.sdio_o = rb_nxt[7];
            end
            if (last_byte) begin
              next_s.st = ASP_TAIL;
            end
          end
        end
      end
      ASP_TAIL: begin
        next_s.wt = s.wt + 1'b1;
        if (s.wt == rel_c - 3'h1) begin
          next_s.sdio_oe = 1'b0;
        end
        if (s.wt == rdy_c - 3'h1) begin
          next_s.ready_n = 1'b1;
          next_s.st = ASP_IDLE;
        end
      end
      default: begin
        next_s.st = ASP_IDLE;
      end
    endcase
    next_s.busy = next_s.st != ASP_IDLE;
    // ----------------------------------------------------------------
    // Conversion period and result refresh
    // ----------------------------------------------------------------
    blocked = s.st != ASP_IDLE && rd && addr < 4'(ASP_RES_BYTES);
    diff = sample_in - {s.regs[ASP_OFS_BASE], s.regs[ASP_OFS_BASE + 4'h1],
      s.regs[ASP_OFS_BASE + 4'h2]};
    prod = diff * {s.regs[ASP_GAIN_BASE], s.regs[ASP_GAIN_BASE + 4'h1],
      s.regs[ASP_GAIN_BASE + 4'h2]};
    next_s.conv = (s.conv == CONV_LAST) ? '0 : s.conv + 1'b1;
    if (s.conv == CONV_LAST) begin
      next_s.ready_n = 1'b1;
      next_s.served = 1'b0;
      if (!blocked) begin
        for (int k = 0; k < ASP_RES_BYTES; k++) begin
          next_s.regs[ASP_RES_BASE + 4'(k)] = prod[ASP_GAIN_FRAC + 23 - 8 * k -: 8];
        end
      end
    end else if (s.conv == '0) begin
      next_s.ready_n = 1'b0;
    end
    // ----------------------------------------------------------------
    // Sync: a long enough low pulse restarts the period on its rise
    // ----------------------------------------------------------------
    if (!s.stb[3]) begin
      if (s.slow != '1) begin
        next_s.slow = s.slow + 1'b1;
      end
      // Rise seen through the synchroniser: one cycle of skew between peers
      // The cycle that sees the rise still counts as a low cycle
      if (s.sh[3][2] && s.sh[3][1] && s.slow >= ASP_SYNC_MIN - 4'h1) begin
        next_s.conv = CONV_RESTART;
        next_s.ready_n = 1'b1;
        next_s.served = 1'b0;
      end
    end else begin
      next_s.slow = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.sh <= '1;
      s.stb <= 4'hf;
      s.ready_n <= 1'b1;
      s.conv <= CONV_LAST;
      s.regs[ASP_OFS_BASE +: 3] <= {ASP_OFS_RST[7:0], ASP_OFS_RST[15:8], ASP_OFS_RST[23:16]};
      s.regs[ASP_GAIN_BASE +: 3] <= {ASP_GAIN_RST[7:0], ASP_GAIN_RST[15:8],
        ASP_GAIN_RST[23:16]};
    end else begin
      s <= next_s;
    end
  end

  assign lnk.sclk_dev_o = s.sclk_o;
  assign lnk.sclk_dev_oe = s.sclk_oe;
  assign lnk.sdio_dev_o = s.sdio_o;
  assign lnk.sdio_dev_oe = s.sdio_oe;
  assign lnk.result_ready_n = s.ready_n;
  assign result_out = {s.regs[ASP_RES_BASE], s.regs[ASP_RES_BASE + 4'h1],
    s.regs[ASP_RES_BASE + 4'h2]};
  assign busy = s.busy;
endmodule
`default_nettype wire

/* File: rtl/asp_pkg_note_unused.sv */
// Intentionally empty companion file kept out of compile
`default_nettype none
`default_nettype wire

/* File: verification/asp_sva.sv */
// Concurrent checks on the link between the converter end and the host end
`timescale 1ns/1ps
`default_nettype none
module asp_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk_dev_oe,
  input wire logic sclk_host_oe,
  input wire logic sdio_dev_oe,
  input wire logic sdio_host_oe,
  input wire logic sclk,
  input wire logic result_ready_n,
  input wire logic cs_n,
  input wire logic conversion_sync_n
);
  logic [4:0] sync_low;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Saturates so a very long sync pulse cannot wrap under the minimum
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_low <= 5'h00;
    end else if (conversion_sync_n) begin
      sync_low <= 5'h00;
    end else if (sync_low != 5'h1f) begin
      sync_low <= sync_low + 5'h01;
    end
  end

  // ------------------------------
  // Sequences
  // ------------------------------
  sequence clk_low6;
    !sclk [*6];
  endsequence
  sequence host_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence ready_stays_high;
    result_ready_n [*8];
  endsequence

  // ------------------------------
  // Assertions
  // ------------------------------
  AST_ONE_CLK_DRIVER: assert property (!(sclk_dev_oe && sclk_host_oe))
    else $error("both ends drive the serial clock");
  AST_ONE_SDIO_DRIVER: assert property (!(sdio_dev_oe && sdio_host_oe))
    else $error("both ends drive the data line");
  AST_TURN_LATE: assert property ($rose(sdio_dev_oe) && !sclk_dev_oe |->
    !$past(sclk, 1) && !$past(sclk, 2) && !$past(sclk, 3))
    else $error("data line turned too soon after the clock fell");
  AST_DATA_LEAD: assert property ($rose(sdio_dev_oe) |-> !sclk [*2])
    else $error("data clock rose too soon after turnaround");
  AST_REL_LATE: assert property ($fell(sdio_dev_oe) && !sclk_dev_oe |->
    !$past(sclk, 1) && !$past(sclk, 2))
    else $error("data line released too soon");
  AST_READY_ENDS: assert property ($fell(sdio_dev_oe) && !result_ready_n |->
    ##[1:3] result_ready_n)
    else $error("ready strobe did not rise after the read");
  AST_READY_HELD: assert property ($rose(result_ready_n) |-> ready_stays_high)
    else $error("ready strobe fell again too soon");
  AST_READY_LEAD: assert property ($fell(result_ready_n) && !sclk_dev_oe |-> clk_low6)
    else $error("clock rose too soon after ready fell");
  AST_SELECT_LEAD: assert property ($fell(cs_n) |-> clk_low6)
    else $error("clock rose too soon after select fell");
  AST_HOST_HALF: assert property ($rose(sclk) && sclk_host_oe |-> host_high_phase)
    else $error("host clock high phase not four cycles");
  AST_SYNC_LEN: assert property ($rose(conversion_sync_n) |-> sync_low >= 5'h0b)
    else $error("sync pulse too short");
  AST_SYNC_RESTART: assert property ($rose(conversion_sync_n) |->
    ##[1:6] ready_stays_high)
    else $error("period did not restart after sync");
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench driving both ends of the serial instruction port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asp_pkg::*;
  localparam int CONV = 800;
  localparam int LIM = 8000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mode_master = 1'b0;
  logic [23:0] sample_in = 24'h000000;
  logic cmd_valid = 1'b0;
  logic [31:0] cmd_data = 32'h00000000;
  logic sync_req = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic busy;
  logic [23:0] rsp_data;
  logic [23:0] result_out;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  // Model register bytes: result, offset, gain, most significant first
  int mem [9] = '{0, 0, 0, 0, 0, 0, 128, 0, 0};

  asp_if asp_if_inst ();
  asp_dev #(.CONV_CYCLES(CONV)) asp_dev_inst (.ref_clk(ref_clk), .rst(rst),
    .lnk(asp_if_inst.dev), .mode_master(mode_master), .sample_in(sample_in),
    .result_out(result_out), .busy(busy));
  asp_host #(.CONV_CYCLES(CONV)) asp_host_inst (.ref_clk(ref_clk), .rst(rst),
    .lnk(asp_if_inst.host), .mode_master(mode_master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .sync_req(sync_req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  asp_sva asp_sva_inst (.ref_clk(ref_clk), .rst(rst),
    .sclk_dev_oe(asp_if_inst.sclk_dev_oe), .sclk_host_oe(asp_if_inst.sclk_host_oe),
    .sdio_dev_oe(asp_if_inst.sdio_dev_oe), .sdio_host_oe(asp_if_inst.sdio_host_oe),
    .sclk(asp_if_inst.sclk), .result_ready_n(asp_if_inst.result_ready_n),
    .cs_n(asp_if_inst.cs_n), .conversion_sync_n(asp_if_inst.conversion_sync_n));

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ------------------------------
  // Checking and model
  // ------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic bound(input int k);
    if (k >= LIM) begin
      err_total++;
      end_sim();
    end
  endtask

  // Unmapped bytes read as zero
  function automatic logic [23:0] expect_rd(input logic [7:0] ins);
    int v;
    v = 0;
    for (int i = 0; i <= ins[6:5]; i++) v = (v << 8) | ((ins[3:0] + i < 9) ? mem[ins[3:0] + i] : 0);
    return 24'(v);
  endfunction

  task automatic refresh_model();
    longint o;
    longint g;
    longint r;
    o = (mem[3] << 16) | (mem[4] << 8) | mem[5];
    g = (mem[6] << 16) | (mem[7] << 8) | mem[8];
    r = ((longint'(sample_in) - o) * g) >>> 23;
    for (int i = 0; i < 3; i++) mem[i] = int'((r >> (16 - 8 * i)) & 255);
  endtask

  // ------------------------------
  // Drivers
  // ------------------------------
  task automatic push(input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_data <= d;
    for (k = 0; k < LIM; k++) begin
      @(negedge ref_clk);
      if (cmd_ready === 1'b1) break;
    end
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    bound(k);
  endtask

  // Result bytes are read only, so the model ignores writes to them
  task automatic wr(input logic [7:0] ins, input logic [23:0] d);
    push({ins, d});
    for (int i = 0; i <= ins[6:5]; i++)
      if (ins[3:0] + i >= 3 && ins[3:0] + i < 9) mem[ins[3:0] + i] = d[23 - 8 * i -: 8];
  endtask

  task automatic rd(input logic [7:0] ins);
    logic [23:0] want;
    int k;
    want = expect_rd(ins);
    push({ins, 24'h000000});
    for (k = 0; k < LIM; k++) begin
      @(negedge ref_clk);
      if (rsp_valid === 1'b1) break;
    end
    bound(k);
    check(rsp_data, want);
  endtask

  task automatic wait_fall();
    logic p;
    int k;
    @(negedge ref_clk);
    p = asp_if_inst.result_ready_n;
    for (k = 0; k < LIM; k++) begin
      @(negedge ref_clk);
      if (p === 1'b1 && asp_if_inst.result_ready_n === 1'b0) break;
      p = asp_if_inst.result_ready_n;
    end
    bound(k);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    void'($urandom(51));
    sample_in <= {4'h1, 20'($urandom)};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wait_fall();
    refresh_model();
    check(result_out, expect_rd(8'hc0));
    rd(8'hc0);
    rd(8'hc3);
    rd(8'hc6);
    wr(8'h00, 24'hff0000);
    rd(8'h80);
    wr(8'h46, 24'h400000);
    wr(8'h24, 24'h001000);
    rd(8'hc4);
    // New sample only after the calibration writes have landed
    @(posedge ref_clk);
    sample_in <= {4'h1, 20'($urandom)};
    @(posedge ref_clk);
    wait_fall();
    refresh_model();
    check(result_out, expect_rd(8'hc0));
    rd(8'hc0);
    // Master operation parks the host queue; the converter runs one frame itself
    @(posedge ref_clk);
    mode_master <= 1'b1;
    for (int i = 0; i < 8; i++) push({8'h09, 24'h000000});
    @(negedge ref_clk);
    check(cmd_ready, 1'b0);
    check(asp_if_inst.sclk_dev_oe, 1'b1);
    wait_fall();
    refresh_model();
    check(result_out, expect_rd(8'hc0));
    repeat (60) @(negedge ref_clk);
    check(asp_if_inst.result_ready_n, 1'b1);
    check(busy, 1'b0);
    @(posedge ref_clk);
    mode_master <= 1'b0;
    rd(8'h89);
    // Sync just after a refresh so no natural refresh hides the restart
    wait_fall();
    @(posedge ref_clk);
    sync_req <= 1'b1;
    t0 = cyc;
    @(posedge ref_clk);
    sync_req <= 1'b0;
    wait_fall();
    check(cyc - t0 >= CONV && cyc - t0 <= CONV + 40, 1'b1);
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
